// file: serial_cmd_pkg.sv
package serial_cmd_pkg;
    // host word layout
    localparam int CMD_W = 16;
    localparam int DATA_W = 8;
    localparam int CH_N = 8;
    localparam int IGNORE_BIT = 31;
    localparam int BIT_WRITE = 15;
    localparam int BIT_RESET = 14;
    localparam int BIT_REQ = 13;
    localparam int BIT_XFER = 12;
    localparam int BIT_START = 11;
    localparam int TYPE_LSB = 8;
    localparam logic [2:0] TYPE_STOP = 3'h0;
    localparam logic [2:0] TYPE_NORMAL = 3'h1;
    localparam logic [2:0] TYPE_SETUP = 3'h7;
    localparam logic [CMD_W-1:0] CMD_HALT_ALL = 16'h0800;
    localparam logic [CMD_W-1:0] CMD_IDLE = 16'h0000;

    // host port map
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_CH_BASE = 6'h20;
    localparam logic [1:0] REG_CS = 2'h3;
    localparam int CS_MODE_LSB = 24;

    // local parameter addresses and fixed values
    localparam logic [7:0] PAR_KIND = 8'h00;
    localparam logic [7:0] PAR_PORT_BITS = 8'h01;
    localparam logic [7:0] PAR_MAJOR = 8'h02;
    localparam logic [7:0] PAR_MINOR = 8'h03;
    localparam logic [7:0] PAR_GP_IN = 8'h04;
    localparam logic [7:0] PAR_GP_OUT = 8'h05;
    localparam logic [7:0] PAR_CPU = 8'h06;
    localparam logic [7:0] PAR_CHANNELS = 8'h07;
    localparam logic [7:0] DATA_PORT_BITS_VAL = 8'h08;
    localparam logic [7:0] GP_COUNT_VAL = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int XFER_TIMEOUT_NS = 200000;
    localparam int unsigned XFER_TIMEOUT_CYC = XFER_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {LINK_PROBE, LINK_INIT, LINK_XFER} link_op_t;
    typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_PROBE, ST_INIT, ST_XFER} ctl_state_t;
endpackage : serial_cmd_pkg

// file: serial_link_command_port.sv
`timescale 1ns/1ps
module serial_link_command_port
    import serial_cmd_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = XFER_TIMEOUT_CYC,
    parameter logic [7:0] KIND_CODE = 8'h5a,   // arbitrary value
    parameter logic [7:0] CPU_CODE = 8'h3c,    // arbitrary value
    parameter logic [7:0] FW_MAJOR = 8'h01,
    parameter logic [7:0] FW_MINOR = 8'h00,
    parameter logic [7:0] CHAN_COUNT = 8'h08
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // host register port
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    output logic cmd_busy,
    // serial channel engine
    output link_op_t link_op,
    output logic [CH_N-1:0] link_req,
    input wire logic [CH_N-1:0] link_ack,
    input wire logic [CH_N-1:0] link_ok,
    input wire logic [CH_N-1:0][31:0] link_rx0,
    input wire logic [CH_N-1:0][31:0] link_rx1,
    input wire logic [CH_N-1:0][31:0] link_rx2,
    input wire logic [CH_N-1:0][7:0] link_fault,
    output logic [CH_N-1:0][31:0] link_tx0,
    output logic [CH_N-1:0][31:0] link_tx1,
    output logic [CH_N-1:0][31:0] link_tx2,
    output logic [CH_N-1:0][7:0] link_mode,
    output logic [CH_N-1:0] link_chatter,
    output logic [CH_N-1:0] link_active
);

    function automatic logic [2:0] ch_of(input logic [ADDR_W-1:0] a);
        return a[4:2];
    endfunction : ch_of

    function automatic logic [1:0] reg_of(input logic [ADDR_W-1:0] a);
        return a[1:0];
    endfunction : reg_of

    function automatic logic is_ch(input logic [ADDR_W-1:0] a);
        return (a & ADDR_CH_BASE) == ADDR_CH_BASE;
    endfunction : is_ch

    ctl_state_t state_q;
    logic [CMD_W-1:0] cmd_q;
    logic [DATA_W-1:0] data_q;
    logic [CH_N-1:0] req_q, fail_q, active_q, found_q, chatter_q, xerr_q;
    logic [31:0] tmo_q;
    link_op_t op_q;
    logic setup_q;
    logic [2:0][CH_N-1:0][31:0] tx_q, rx_q;
    logic [CH_N-1:0][7:0] mode_q, fault_q;
    logic [CH_N-1:0] exist;

    // command decode
    logic wr_cmd, halt_cmd, rst_cmd, accept;
    logic [CH_N-1:0] acked, left, fail_nxt, mask, clr_mask;
    logic timeout, step_done, stop_ind;
    logic [2:0] cmd_type;

    always_comb begin
        for (int i = 0; i < CH_N; i++) begin
            exist[i] = 8'(i) < CHAN_COUNT;
        end
    end

    assign wr_cmd = host_wr && host_addr == ADDR_CMD && !host_wdata[IGNORE_BIT];
    assign halt_cmd = host_wdata[CMD_W-1:0] == CMD_HALT_ALL;
    assign rst_cmd = host_wdata[BIT_RESET];
    // a busy interpreter only takes the commands that abort it
    assign accept = wr_cmd && ((state_q == ST_IDLE && cmd_q == CMD_IDLE) || halt_cmd || rst_cmd);
    assign mask = cmd_q[CH_N-1:0];
    assign cmd_type = cmd_q[TYPE_LSB +: 3];
    assign stop_ind = state_q == ST_DECODE && !cmd_q[BIT_REQ] && !cmd_q[BIT_XFER]
        && cmd_q[BIT_START] && cmd_type == TYPE_STOP;
    assign acked = link_ack & req_q;
    assign left = req_q & ~acked;
    assign timeout = tmo_q == TIMEOUT_CYCLES - 1;
    assign step_done = left == '0 || timeout;
    assign fail_nxt = fail_q | (acked & ~link_ok) | (timeout ? left : '0);
    assign clr_mask = (accept && (halt_cmd || rst_cmd)) ? '1 : (stop_ind ? mask : '0);

    function automatic logic [7:0] param_value(input logic [7:0] a);
        case (a)
            PAR_KIND: return KIND_CODE;
            PAR_PORT_BITS: return DATA_PORT_BITS_VAL;
            PAR_MAJOR: return FW_MAJOR;
            PAR_MINOR: return FW_MINOR;
            PAR_GP_IN: return GP_COUNT_VAL;
            PAR_GP_OUT: return GP_COUNT_VAL;
            PAR_CPU: return CPU_CODE;
            PAR_CHANNELS: return CHAN_COUNT;
            default: return 8'h00;
        endcase
    endfunction : param_value

    // command sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            cmd_q <= CMD_IDLE;
            data_q <= 8'h00;
            req_q <= '0;
            fail_q <= '0;
            active_q <= '0;
            found_q <= '0;
            chatter_q <= '0;
            xerr_q <= '0;
            tmo_q <= 32'h0;
            op_q <= LINK_PROBE;
            setup_q <= 1'b0;
        end else begin
            if (host_wr && host_addr == ADDR_DATA) begin
                data_q <= host_wdata[DATA_W-1:0];
            end
            if (accept && (halt_cmd || rst_cmd)) begin
                // abort anything in flight and forget all channels
                state_q <= ST_IDLE;
                cmd_q <= CMD_IDLE;
                req_q <= '0;
                active_q <= '0;
                found_q <= '0;
                chatter_q <= '0;
                xerr_q <= '0;
            end else if (accept) begin
                cmd_q <= host_wdata[CMD_W-1:0];
                state_q <= ST_DECODE;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                    end
                    ST_DECODE: begin
                        fail_q <= '0;
                        tmo_q <= 32'h0;
                        state_q <= ST_IDLE;
                        cmd_q <= CMD_IDLE;
                        if (cmd_q[BIT_REQ]) begin
                            if (!cmd_q[BIT_WRITE]) begin
                                data_q <= param_value(cmd_q[7:0]);
                            end
                        end else if (cmd_q[BIT_XFER]) begin
                            chatter_q <= '0;
                            fail_q <= mask & ~active_q;
                            req_q <= mask & active_q;
                            op_q <= LINK_XFER;
                            if ((mask & active_q) != '0) begin
                                state_q <= ST_XFER;
                                cmd_q <= cmd_q;
                            end else begin
                                data_q <= mask & ~active_q;
                            end
                        end else if (cmd_q[BIT_START]) begin
                            if (cmd_type == TYPE_STOP) begin
                                active_q <= active_q & ~mask;
                                chatter_q <= chatter_q & ~mask;
                            end else if (cmd_type == TYPE_NORMAL || cmd_type == TYPE_SETUP) begin
                                setup_q <= cmd_type == TYPE_SETUP;
                                cmd_q <= cmd_q;
                                fail_q <= mask & ~exist;
                                // discovery only for channels not known since the last halt-all or reset-bit command
                                req_q <= mask & exist & ~found_q;
                                op_q <= LINK_PROBE;
                                state_q <= ST_PROBE;
                            end
                        end
                    end
                    ST_PROBE: begin
                        req_q <= left;
                        fail_q <= fail_nxt;
                        tmo_q <= tmo_q + 32'h1;
                        // a card counts as found in the cycle it answers, not only the last one
                        found_q <= found_q | (acked & link_ok);
                        if (step_done) begin
                            req_q <= '0;
                            tmo_q <= 32'h0;
                            if (setup_q) begin
                                active_q <= active_q | (mask & exist & ~fail_nxt);
                                data_q <= fail_nxt;
                                cmd_q <= CMD_IDLE;
                                state_q <= ST_IDLE;
                            end else begin
                                req_q <= mask & exist & ~fail_nxt;
                                op_q <= LINK_INIT;
                                state_q <= ST_INIT;
                            end
                        end
                    end
                    ST_INIT, ST_XFER: begin
                        req_q <= left;
                        fail_q <= fail_nxt;
                        tmo_q <= tmo_q + 32'h1;
                        if (state_q == ST_XFER) begin
                            xerr_q <= (xerr_q & ~acked) | (acked & ~link_ok);
                        end
                        if (step_done) begin
                            req_q <= '0;
                            tmo_q <= 32'h0;
                            data_q <= fail_nxt;
                            cmd_q <= CMD_IDLE;
                            state_q <= ST_IDLE;
                            if (state_q == ST_XFER) begin
                                xerr_q <= xerr_q | fail_nxt;
                            end else begin
                                active_q <= active_q | (mask & exist & ~fail_nxt);
                                chatter_q <= chatter_q | (mask & exist & ~fail_nxt);
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // host-written outgoing data and remote mode byte
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_q <= '0;
            mode_q <= '0;
        end else if (host_wr && is_ch(host_addr)) begin
            if (reg_of(host_addr) == REG_CS) begin
                mode_q[ch_of(host_addr)] <= host_wdata[CS_MODE_LSB +: 8];
            end else begin
                tx_q[reg_of(host_addr)][ch_of(host_addr)] <= host_wdata;
            end
        end
    end

    // incoming setup or process data, wiped on halt-all
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_q <= '0;
        end else begin
            for (int i = 0; i < CH_N; i++) begin
                if (accept && (halt_cmd || rst_cmd)) begin
                    rx_q[0][i] <= 32'h0;
                    rx_q[1][i] <= 32'h0;
                    rx_q[2][i] <= 32'h0;
                end else if (acked[i] && link_ok[i] && state_q != ST_INIT) begin
                    rx_q[0][i] <= link_rx0[i];
                    rx_q[1][i] <= link_rx1[i];
                    rx_q[2][i] <= link_rx2[i];
                end
            end
        end
    end

    // sticky local faults, cleared only by a stop, a halt-all or a reset-bit command
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fault_q <= '0;
        end else begin
            for (int i = 0; i < CH_N; i++) begin
                // a new fault in the clearing cycle is kept
                fault_q[i] <= (clr_mask[i] ? 8'h00 : fault_q[i]) | link_fault[i];
            end
        end
    end

    // registered read port, one cycle after the strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            host_rdata <= 32'h0;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_rd;
            if (host_rd) begin
                if (host_addr == ADDR_CMD) begin
                    host_rdata <= {16'h0, cmd_q};
                end else if (host_addr == ADDR_DATA) begin
                    host_rdata <= {24'h0, data_q};
                end else if (is_ch(host_addr) && reg_of(host_addr) == REG_CS) begin
                    host_rdata <= {mode_q[ch_of(host_addr)], 8'(state_q),
                        ~active_q[ch_of(host_addr)], ~found_q[ch_of(host_addr)],
                        xerr_q[ch_of(host_addr)], 5'h0, fault_q[ch_of(host_addr)]};
                end else if (is_ch(host_addr)) begin
                    host_rdata <= rx_q[reg_of(host_addr)][ch_of(host_addr)];
                end else begin
                    host_rdata <= 32'h0;
                end
            end
        end
    end

    assign cmd_busy = cmd_q != CMD_IDLE;
    assign link_op = op_q;
    assign link_req = req_q;
    assign link_tx0 = tx_q[0];
    assign link_tx1 = tx_q[1];
    assign link_tx2 = tx_q[2];
    assign link_mode = mode_q;
    assign link_chatter = chatter_q;
    assign link_active = active_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_CMD_LOAD: assert property (accept && !halt_cmd && !rst_cmd
        |=> cmd_q == $past(host_wdata[CMD_W-1:0]))
        else $error("accepted command not held in command register");
    AST_IGNORE: assert property (host_wr && host_addr == ADDR_CMD
        && host_wdata[IGNORE_BIT] && state_q == ST_IDLE && cmd_q == CMD_IDLE
        |=> cmd_q == CMD_IDLE && state_q == ST_IDLE)
        else $error("ignored command write took effect");
    AST_BUSY_HOLD: assert property (cmd_busy && !accept
        |=> cmd_q == $past(cmd_q) || cmd_q == CMD_IDLE)
        else $error("command register changed while busy");
    AST_HALT: assert property (accept && halt_cmd
        |=> cmd_q == CMD_IDLE && active_q == '0 && found_q == '0 && req_q == '0)
        else $error("halt-all left channel state behind");
    AST_STOP_IND: assert property (stop_ind
        |=> (active_q & $past(mask)) == '0 && found_q == $past(found_q))
        else $error("individual stop wrong");
    AST_PARAM: assert property (state_q == ST_DECODE && cmd_q[BIT_REQ]
        && !cmd_q[BIT_WRITE] && cmd_q[7:0] == PAR_PORT_BITS && !accept
        |=> data_q == DATA_PORT_BITS_VAL ##1 !cmd_busy || accept)
        else $error("port width parameter misread");
    AST_CHATTER_OFF: assert property (state_q == ST_DECODE && cmd_q[BIT_XFER]
        && !cmd_q[BIT_REQ] && !accept |=> chatter_q == '0)
        else $error("keepalive survived a transfer command");
    AST_TIMEOUT: assert property (tmo_q < TIMEOUT_CYCLES)
        else $error("transfer wait ran past its timeout");
    AST_REQ_MASK: assert property ((req_q & ~mask) == '0)
        else $error("request on channel outside the mask");
    AST_DONE_DATA: assert property ((state_q == ST_INIT || state_q == ST_XFER)
        && step_done && !accept |=> data_q == $past(fail_nxt) && cmd_q == CMD_IDLE)
        else $error("completion mask not reported");
    AST_XFER_REQ: assert property (state_q == ST_DECODE && cmd_q[BIT_XFER]
        && !cmd_q[BIT_REQ] && !accept |=> req_q == $past(mask & active_q))
        else $error("transfer requested on wrong channels");
    AST_START_PROBE: assert property (state_q == ST_DECODE && cmd_q[BIT_START]
        && !cmd_q[BIT_REQ] && !cmd_q[BIT_XFER] && cmd_type == TYPE_NORMAL && !accept
        |=> req_q == $past(mask & exist & ~found_q) && state_q == ST_PROBE)
        else $error("start probed the wrong channels");
    AST_FAULT_KEEP: assert property (link_fault != '0
        |=> (fault_q & $past(link_fault)) == $past(link_fault))
        else $error("new local fault was lost");

    COV_START: cover property (state_q == ST_INIT ##[1:20] state_q == ST_IDLE);
    COV_XFER_FAIL: cover property (state_q == ST_XFER && step_done && fail_nxt != '0);
    COV_HALT_BUSY: cover property (cmd_busy && accept && halt_cmd);
    COV_STOP_IND: cover property (stop_ind && mask != '0);

endmodule : serial_link_command_port

// file: link_engine_model.sv
`timescale 1ns/1ps
module link_engine_model
    import serial_cmd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // requests and bench controls
    input wire logic [CH_N-1:0] link_req,
    input wire logic [CH_N-1:0] card_present,
    input wire logic [7:0] ack_delay,
    // answers
    output logic [CH_N-1:0] link_ack,
    output logic [CH_N-1:0] link_ok,
    output logic [CH_N-1:0][31:0] link_rx0,
    output logic [CH_N-1:0][31:0] link_rx1,
    output logic [CH_N-1:0][31:0] link_rx2
);
    logic [CH_N-1:0][7:0] wait_q;

    // an absent card never answers, so the interpreter has to time out
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wait_q <= '0;
            link_ack <= '0;
        end else begin
            for (int i = 0; i < CH_N; i++) begin
                link_ack[i] <= 1'b0;
                if (!link_req[i] || link_ack[i]) begin
                    wait_q[i] <= '0;
                end else if (card_present[i] && wait_q[i] == ack_delay) begin
                    link_ack[i] <= 1'b1;
                end else begin
                    wait_q[i] <= wait_q[i] + 8'h01;
                end
            end
        end
    end

    assign link_ok = link_ack;

    // words are only valid with the ack; inverted otherwise so stale data shows
    always_comb begin
        for (int i = 0; i < CH_N; i++) begin
            link_rx0[i] = link_ack[i] ? {24'h0000a1, i[7:0]} : ~{24'h0000a1, i[7:0]};
            link_rx1[i] = link_ack[i] ? 32'h4b524f57 : 32'hb4adb0a8;
            link_rx2[i] = link_ack[i] ? 32'h01000200 : 32'hfefffdff;
        end
    end
endmodule : link_engine_model

// file: serial_link_command_port_bench.sv
`timescale 1ns/1ps
module serial_link_command_port_bench;
    import serial_cmd_pkg::*;
    localparam logic [7:0] KIND = 8'h5a; // arbitrary value
    localparam logic [7:0] CPU = 8'h3c; // arbitrary value
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] host_addr = '0;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [31:0] host_wdata = '0;
    logic [31:0] host_rdata;
    logic host_rvalid;
    logic cmd_busy;
    link_op_t link_op;
    logic [CH_N-1:0] link_req, link_ack, link_ok, link_chatter, link_active;
    logic [CH_N-1:0] card_present = '0;
    logic [7:0] ack_delay = 8'h02;
    logic [CH_N-1:0][31:0] link_rx0, link_rx1, link_rx2, link_tx0;
    logic [CH_N-1:0][7:0] link_mode;
    logic [CH_N-1:0][7:0] link_fault = '0;
    logic [31:0] rv;
    int err_total = 0;
    int n_checks = 0;

    always #2 core_clk = ~core_clk;

    serial_link_command_port #(.TIMEOUT_CYCLES(16), .KIND_CODE(KIND), .CPU_CODE(CPU),
        .FW_MAJOR(8'h01), .FW_MINOR(8'h00), .CHAN_COUNT(8'h08)) dut (
        .core_clk(core_clk), .resetn(resetn), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .cmd_busy(cmd_busy), .link_op(link_op),
        .link_req(link_req), .link_ack(link_ack), .link_ok(link_ok), .link_rx0(link_rx0),
        .link_rx1(link_rx1), .link_rx2(link_rx2), .link_fault(link_fault),
        .link_tx0(link_tx0), .link_tx1(), .link_tx2(), .link_mode(link_mode),
        .link_chatter(link_chatter),
        .link_active(link_active));

    link_engine_model far (.core_clk(core_clk), .resetn(resetn), .link_req(link_req),
        .card_present(card_present), .ack_delay(ack_delay), .link_ack(link_ack),
        .link_ok(link_ok), .link_rx0(link_rx0), .link_rx1(link_rx1), .link_rx2(link_rx2));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk) #1;
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(posedge core_clk) #1;
        host_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        int n;
        @(posedge core_clk) #1;
        host_addr = a;
        host_rd = 1'b1;
        @(posedge core_clk) #1;
        host_rd = 1'b0;
        n = 0;
        while (host_rvalid !== 1'b1 && n < 4) begin
            @(posedge core_clk) #1;
            n++;
        end
        d = host_rdata;
    endtask : rd

    // poll bound covers the longest probe, init and timeout chain
    task automatic idle();
        int n;
        n = 0;
        rv = 32'h1;
        while (rv !== 32'h0 && n < 300) begin
            rd(ADDR_CMD, rv);
            n++;
        end
        chk("command cleared", 32'h0, rv);
    endtask : idle

    task automatic run(input logic [31:0] c, input logic [7:0] exp_data);
        wr(ADDR_CMD, c);
        idle();
        rd(ADDR_DATA, rv);
        chk("data register", {24'h0, exp_data}, rv);
    endtask : run

    task automatic t_params();
        logic [7:0] exp [8];
        exp = '{KIND, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00, CPU, 8'h08};
        for (int a = 0; a < 8; a++) begin
            run({24'h000020, a[7:0]}, exp[a]);
        end
    endtask : t_params

    task automatic t_start();
        card_present = 8'h01;
        ack_delay = 8'h0a;
        wr(ADDR_CMD, 32'h00ff_0903);
        rd(ADDR_CMD, rv);
        chk("busy readback", 32'h0000_0903, rv);
        chk("busy flag", 32'h1, {31'h0, cmd_busy});
        wr(ADDR_CMD, 32'h8000_0800);
        rd(ADDR_CMD, rv);
        chk("ignored write", 32'h0000_0903, rv);
        idle();
        rd(ADDR_DATA, rv);
        chk("start fail mask", 32'h02, rv);
        chk("active", 32'h01, {24'h0, link_active});
        chk("chatter", 32'h01, {24'h0, link_chatter});
        rd(ADDR_CH_BASE, rv);
        chk("unit number", 32'h0000a100, rv);
    endtask : t_start

    task automatic t_xfer();
        ack_delay = 8'h02;
        wr(ADDR_CH_BASE, 32'h1234abcd);
        chk("tx word", 32'h1234abcd, link_tx0[0]);
        wr(ADDR_CH_BASE + 6'h03, 32'h0200_0000);
        chk("mode byte", 32'h02, {24'h0, link_mode[0]});
        run(32'h1003, 8'h02);
        chk("chatter off", 32'h0, {24'h0, link_chatter});
        card_present = 8'h00;
        run(32'h1001, 8'h01);
    endtask : t_xfer

    task automatic t_stop();
        card_present = 8'h03;
        // halt-all leaves the data register with the last transfer mask
        run(32'h0800, 8'h01);
        run(32'h0903, 8'h00);
        @(posedge core_clk) #1;
        link_fault[0] = 8'h08;
        @(posedge core_clk) #1;
        link_fault[0] = 8'h00;
        rd(ADDR_CH_BASE + 6'h03, rv);
        chk("fault latched", 32'h0200_0008, rv);
        run(32'h0801, 8'h00);
        chk("individual stop", 32'h02, {24'h0, link_active});
        rd(ADDR_CH_BASE + 6'h03, rv);
        chk("stop clears fault", 32'h0200_8000, rv);
        rd(ADDR_CH_BASE + 6'h04, rv);
        chk("kept unit", 32'h0000a101, rv);
        ack_delay = 8'h30;
        wr(ADDR_CMD, 32'h0901);
        wr(ADDR_CMD, 32'h0800);
        idle();
        chk("halt all", 32'h0, {16'h0, link_active, link_chatter});
        rd(ADDR_CH_BASE + 6'h04, rv);
        chk("cleared unit", 32'h0, rv);
        ack_delay = 8'h02;
        run(32'h0f01, 8'h00);
        run(32'h4000, 8'h00);
        chk("reset bit", 32'h0, {24'h0, link_active});
    endtask : t_stop

    task automatic t_pwrite();
        wr(ADDR_CMD, 32'h8000_2001);
        rd(ADDR_CMD, rv);
        chk("ignored idle write", 32'h0, rv);
        wr(ADDR_DATA, 32'h77);
        run(32'ha003, 8'h77);
        run(32'h2003, 8'h00);
    endtask : t_pwrite

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (16) @(posedge core_clk);
        #1 resetn = 1'b1;
        chk("active after reset", 32'h0, {24'h0, link_active});
        t_params();
        t_start();
        t_xfer();
        t_stop();
        t_pwrite();
        close_out();
    end

    // whole run needs a few hundred cycles
    initial begin
        #100000;
        err_total++;
        close_out();
    end
endmodule : serial_link_command_port_bench
